// >>> rtl/pcp_fifo.sv
`timescale 1ns/1ps
module pcp_fifo #(
  parameter int unsigned W = 32,
  parameter int unsigned DEPTH = 8
) (
  // Clock and control
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_en,
  input wire logic i_clr,
  // Stream
  pcp_stream_if.store s
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  logic [W-1:0] head_q;
  logic head_v_q;

  wire [AW:0] used = wp_q - rp_q;
  wire full = (used == (AW+1)'(DEPTH));
  wire take = s.wr_valid & ~full;
  wire pop = s.rd_ready & head_v_q;
  wire load = (used != '0) & (~head_v_q | pop);

  assign s.wr_ready = ~full;
  assign s.rd_valid = head_v_q;
  assign s.rd_data = head_q;

  always_ff @(posedge i_clk) begin
    if (i_en && take && !i_clr) begin
      mem[wp_q[AW-1:0]] <= s.wr_data;
    end
  end

  // Head register keeps read data coming from a flop
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      head_q <= '0;
      head_v_q <= 1'b0;
    end else if (i_en) begin
      if (i_clr) begin
        wp_q <= '0;
        rp_q <= '0;
        head_v_q <= 1'b0;
      end else begin
        if (take) begin
          wp_q <= wp_q + 1'b1;
        end
        if (load) begin
          head_q <= mem[rp_q[AW-1:0]];
          rp_q <= rp_q + 1'b1;
          head_v_q <= 1'b1;
        end else if (pop) begin
          head_v_q <= 1'b0;
        end
      end
    end
  end
endmodule

// >>> rtl/pcp_loader.sv
`timescale 1ns/1ps
// Behaviour
// - Ratio 1 plain, 4 with security only, 8 whenever decompression is on.
// - Status line pulled low within 600 ns of request going low.
// - Complete line driven low within 600 ns of request going low.
// - Status held low between 268 and 1506 us without extended pulse.
// - Status released within 1506 us after request rises, unless held outside.
// - Data latched only on rising edges of the configuration clock.
// - Internal oscillator init: user mode 175 to 437 us after complete rises.
// - User init clock: user mode after enable delay plus 8576 clock periods.
module pcp_loader #(
  parameter int unsigned STATUS_LOW_CYC = pcp_pkg::STATUS_LOW_CYC,
  parameter int unsigned INIT_OSC_CYC = pcp_pkg::INIT_OSC_CYC,
  parameter int unsigned INIT_OSC_MAX_CYC = pcp_pkg::INIT_OSC_MAX_CYC,
  parameter int unsigned INIT_USR_EDGES = pcp_pkg::INIT_USR_EDGES,
  parameter int unsigned FIFO_DEPTH = pcp_pkg::FIFO_DEPTH
) (
  // Clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Configuration link pins
  input wire logic i_config_clock,
  input wire logic i_config_request_n,
  input wire logic [pcp_pkg::WORD_W-1:0] i_config_data_bus,
  input wire logic i_user_init_clock,
  input wire logic i_config_status_n,
  output logic o_config_status_n_o,
  output logic o_config_status_n_oe,
  output logic o_config_complete_o,
  output logic o_config_complete_oe,
  output logic o_user_mode
);
  import pcp_pkg::*;

  localparam logic [CNT_W-1:0] ST_LOW_LAST = CNT_W'(STATUS_LOW_CYC - 1);
  localparam logic [CNT_W-1:0] OSC_LAST = CNT_W'(INIT_OSC_CYC - 1);
  localparam logic [CNT_W-1:0] CU_LAST = CNT_W'(CD2CU_CYC);
  localparam logic [CNT_W-1:0] USR_LAST = CNT_W'(CD2CU_CYC + INIT_USR_EDGES - 1);

  // Reset release
  logic [1:0] rst_q;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  wire rst_n = rst_q[1];

  // Pin synchronisers, third stage only on the two clocks
  wire [PIN_W-1:0] pin_raw = {i_user_init_clock, i_config_status_n, i_config_request_n, i_config_clock,
                              i_config_data_bus};
  logic [PIN_W-1:0] pin1_q;
  logic [PIN_W-1:0] pin2_q;
  logic [1:0] clk3_q;
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin1_q <= {PIN_W{1'b1}};
      pin2_q <= {PIN_W{1'b1}};
      clk3_q <= 2'h3;
    end else if (i_ce) begin
      pin1_q <= pin_raw;
      pin2_q <= pin1_q;
      clk3_q <= {pin2_q[PIN_UCLK], pin2_q[PIN_CCLK]};
    end
  end
  wire cclk_rise = pin2_q[PIN_CCLK] & ~clk3_q[0];
  wire uclk_rise = pin2_q[PIN_UCLK] & ~clk3_q[1];
  wire req_n = pin2_q[PIN_REQ];
  wire line_st_n = pin2_q[PIN_STAT];
  wire [31:0] din = pin2_q[WORD_W-1:0];

  // Software registers
  logic [31:0] ctrl_q;
  logic [15:0] len_q;
  logic ovf_q;
  logic pready_q;

  wire [1:0] width_bits = ctrl_q[CTRL_WIDTH_LSB +: 2];
  wire pcp_width_t cfg_width = pcp_width_t'(width_bits);
  wire usr_sel = ctrl_q[CTRL_USRCLK_BIT];
  wire [3:0] ratio = ctrl_q[CTRL_DECOMP_BIT] ? RATIO_DEC : (ctrl_q[CTRL_SEC_BIT] ? RATIO_SEC : RATIO_PLAIN);

  // Loader state
  pcp_state_t state_q;
  pcp_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [3:0] ph_q;
  logic [3:0] ph_d;
  logic [4:0] lc_q;
  logic [4:0] lc_d;
  logic [31:0] asm_q;
  logic [31:0] asm_d;
  logic [15:0] wcnt_q;
  logic [15:0] wcnt_d;
  logic push;
  logic ovf_evt;

  pcp_stream_if #(.W(WORD_W)) fifo_if();

  // Unit packing: lanes fill the word from the least significant end
  wire [4:0] lane_last = (cfg_width == PCP_W_X8) ? 5'h03 :
                         (cfg_width == PCP_W_X16) ? 5'h01 :
                         (cfg_width == PCP_W_X32) ? 5'h00 : 5'h1F;
  wire [31:0] unit_word = (cfg_width == PCP_W_X8) ? {din[7:0], asm_q[31:8]} :
                          (cfg_width == PCP_W_X16) ? {din[15:0], asm_q[31:16]} :
                          (cfg_width == PCP_W_X32) ? din : {din[0], asm_q[31:1]};
  wire lane_done = (lc_q == lane_last);
  wire [3:0] ph_next = (ph_q == ratio - 4'h1) ? 4'h0 : ph_q + 4'h1;
  wire [15:0] wcnt_inc = wcnt_q + 16'h0001;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    ph_d = ph_q;
    lc_d = lc_q;
    asm_d = asm_q;
    wcnt_d = wcnt_q;
    push = 1'b0;
    ovf_evt = 1'b0;
    case (state_q)
      PCP_ST_RESET: begin
        if (cnt_q != ST_LOW_LAST) begin
          cnt_d = cnt_q + 1'b1;
        end else if (req_n) begin
          state_d = PCP_ST_LOAD;
          cnt_d = '0;
          ph_d = 4'h0;
          lc_d = 5'h00;
          wcnt_d = 16'h0000;
        end
      end
      PCP_ST_LOAD: begin
        // Waits while the status line is still held low from outside
        if (cclk_rise && line_st_n) begin
          ph_d = ph_next;
          if (ph_q == 4'h0) begin
            asm_d = unit_word;
            lc_d = lane_done ? 5'h00 : lc_q + 5'h01;
            if (lane_done) begin
              if (!fifo_if.wr_ready) begin
                ovf_evt = 1'b1;
                state_d = PCP_ST_ERROR;
              end else begin
                push = 1'b1;
                wcnt_d = wcnt_inc;
                if (wcnt_inc == len_q) begin
                  state_d = (ratio == RATIO_PLAIN) ? PCP_ST_INIT : PCP_ST_TAIL;
                  cnt_d = '0;
                end
              end
            end
          end
        end
      end
      PCP_ST_TAIL: begin
        if (cclk_rise) begin
          ph_d = ph_next;
          if (ph_q == ratio - 4'h1) begin
            state_d = PCP_ST_INIT;
          end
        end
      end
      PCP_ST_INIT: begin
        if (!usr_sel) begin
          if (cnt_q == OSC_LAST) begin
            state_d = PCP_ST_USER;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end else if (cnt_q < CU_LAST || uclk_rise) begin
          if (cnt_q == USR_LAST) begin
            state_d = PCP_ST_USER;
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
      end
      PCP_ST_USER: state_d = PCP_ST_USER;
      PCP_ST_ERROR: state_d = PCP_ST_ERROR;
      default: state_d = PCP_ST_RESET;
    endcase
    if (!req_n) begin
      state_d = PCP_ST_RESET;
      if (state_q != PCP_ST_RESET) begin
        cnt_d = '0;
      end
    end
  end

  wire stat_oe_d = (state_d == PCP_ST_RESET) || (state_d == PCP_ST_ERROR);
  wire done_oe_d = (state_d != PCP_ST_INIT) && (state_d != PCP_ST_USER);

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= PCP_ST_RESET;
      cnt_q <= '0;
      ph_q <= 4'h0;
      lc_q <= 5'h00;
      asm_q <= 32'h0000_0000;
      wcnt_q <= 16'h0000;
    end else if (i_ce) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      ph_q <= ph_d;
      lc_q <= lc_d;
      asm_q <= asm_d;
      wcnt_q <= wcnt_d;
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_config_status_n_o <= 1'b0;
      o_config_complete_o <= 1'b0;
      o_config_status_n_oe <= 1'b1;
      o_config_complete_oe <= 1'b1;
      o_user_mode <= 1'b0;
    end else if (i_ce) begin
      o_config_status_n_oe <= stat_oe_d;
      o_config_complete_oe <= done_oe_d;
      o_user_mode <= (state_d == PCP_ST_USER);
    end
  end

  // Word buffer, drained by software through the data register
  wire acc = i_psel & i_penable;
  wire fin = acc & pready_q;
  wire hit_ctrl = (i_paddr == OFF_CTRL);
  wire hit_len = (i_paddr == OFF_LEN);
  wire hit_status = (i_paddr == OFF_STATUS);
  wire hit_data = (i_paddr == OFF_DATA);
  wire hit_any = hit_ctrl | hit_len | hit_status | hit_data;
  wire pop = fin & ~i_pwrite & hit_data & fifo_if.rd_valid;
  wire ovf_clr = fin & i_pwrite & hit_status & i_pwdata[ST_OVF_BIT];

  assign fifo_if.wr_valid = push;
  assign fifo_if.wr_data = unit_word;
  assign fifo_if.rd_ready = pop;

  pcp_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(i_ref_clk),
    .i_rst_n(rst_n),
    .i_en(i_ce),
    .i_clr(state_q == PCP_ST_RESET),
    .s(fifo_if.store)
  );

  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_STATE_LSB +: 3] = state_q;
    status_word[ST_HEAD_BIT] = fifo_if.rd_valid;
    status_word[ST_OVF_BIT] = ovf_q;
    status_word[ST_USER_BIT] = o_user_mode;
    status_word[ST_WCNT_LSB +: 16] = wcnt_q;
  end

  wire [31:0] rdata = hit_ctrl ? ctrl_q :
                      hit_len ? {16'h0000, len_q} :
                      hit_status ? status_word :
                      (hit_data & fifo_if.rd_valid) ? fifo_if.rd_data : 32'h0000_0000;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (i_ce) begin
      pready_q <= acc & ~pready_q;
      o_prdata <= (acc & ~pready_q & ~i_pwrite) ? rdata : 32'h0000_0000;
      o_pslverr <= acc & ~pready_q & ~hit_any;
    end
  end
  assign o_pready = pready_q;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
      len_q <= LEN_RST;
      ovf_q <= 1'b0;
    end else if (i_ce) begin
      if (fin && i_pwrite && hit_ctrl) begin
        ctrl_q <= i_pwdata;
      end
      if (fin && i_pwrite && hit_len) begin
        len_q <= i_pwdata[15:0];
      end
      ovf_q <= ovf_evt | (ovf_q & ~ovf_clr);
    end
  end

  // Helper counters for the checks below
  logic [CNT_W-1:0] low_run_q;
  logic [CNT_W-1:0] init_run_q;
  logic [CNT_W-1:0] uedge_q;
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_run_q <= '0;
      init_run_q <= '0;
      uedge_q <= '0;
    end else if (i_ce) begin
      low_run_q <= !o_config_status_n_oe ? '0 : ((&low_run_q) ? low_run_q : low_run_q + 1'b1);
      init_run_q <= (state_q == PCP_ST_RESET) ? '0 : ((state_q == PCP_ST_INIT) ? init_run_q + 1'b1 : init_run_q);
      uedge_q <= (state_q == PCP_ST_RESET) ? '0 : ((state_q == PCP_ST_INIT && uclk_rise) ? uedge_q + 1'b1 : uedge_q);
    end
  end

  property p_req_status;
    @(posedge i_ref_clk) disable iff (!rst_n) (i_ce && !req_n) |=> o_config_status_n_oe;
  endproperty
  a_req_status: assert property (p_req_status) else $error("status line not pulled low after request");

  property p_req_complete;
    @(posedge i_ref_clk) disable iff (!rst_n) (i_ce && !req_n) |=> (o_config_complete_oe && !o_user_mode);
  endproperty
  a_req_complete: assert property (p_req_complete) else $error("complete line not driven low after request");

  property p_status_min;
    @(posedge i_ref_clk) disable iff (!rst_n) $fell(o_config_status_n_oe) |-> (low_run_q >= STATUS_LOW_CYC);
  endproperty
  a_status_min: assert property (p_status_min) else $error("status low pulse too short");

  property p_status_release;
    @(posedge i_ref_clk) disable iff (!rst_n)
      (i_ce && state_q == PCP_ST_RESET && req_n && cnt_q == ST_LOW_LAST) |=> !o_config_status_n_oe;
  endproperty
  a_status_release: assert property (p_status_release) else $error("status line not released");

  property p_ratio_gap;
    @(posedge i_ref_clk) disable iff (!rst_n) (state_q == PCP_ST_LOAD && ph_q != 4'h0) |-> !push;
  endproperty
  a_ratio_gap: assert property (p_ratio_gap) else $error("word taken inside ratio gap");

  property p_sample_edge;
    @(posedge i_ref_clk) disable iff (!rst_n) push |-> (cclk_rise && state_q == PCP_ST_LOAD && line_st_n);
  endproperty
  a_sample_edge: assert property (p_sample_edge) else $error("word taken without a rising clock edge");

  property p_tail;
    @(posedge i_ref_clk) disable iff (!rst_n)
      (i_ce && req_n && state_q == PCP_ST_TAIL && cclk_rise && ph_q == ratio - 4'h1) |=> state_q == PCP_ST_INIT;
  endproperty
  a_tail: assert property (p_tail) else $error("tail edges not ended correctly");

  property p_osc_init;
    @(posedge i_ref_clk) disable iff (!rst_n)
      ($rose(o_user_mode) && !usr_sel) |-> (init_run_q >= INIT_OSC_CYC && init_run_q <= INIT_OSC_MAX_CYC);
  endproperty
  a_osc_init: assert property (p_osc_init) else $error("oscillator init time out of range");

  property p_usr_init;
    @(posedge i_ref_clk) disable iff (!rst_n)
      ($rose(o_user_mode) && usr_sel) |-> (uedge_q >= INIT_USR_EDGES && init_run_q > CD2CU_CYC);
  endproperty
  a_usr_init: assert property (p_usr_init) else $error("user clock init ended early");
endmodule

// >>> rtl/pcp_pkg.sv
package pcp_pkg;

  // Reference clock
  localparam int unsigned CLK_PERIOD_NS = 40;

  // Reset handshake timing
  localparam int unsigned T_CF2ST0_MAX_NS = 600;
  localparam int unsigned REQ_RESP_MAX_CYC = T_CF2ST0_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned T_STATUS_MIN_US = 268;
  localparam int unsigned STATUS_LOW_CYC = (T_STATUS_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_STATUS_MAX_US = 1506;
  localparam int unsigned STATUS_LOW_MAX_CYC = T_STATUS_MAX_US * 1000 / CLK_PERIOD_NS;

  // Initialization timing
  localparam int unsigned T_CD2UM_MIN_US = 175;
  localparam int unsigned INIT_OSC_CYC = (T_CD2UM_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_CD2UM_MAX_US = 437;
  localparam int unsigned INIT_OSC_MAX_CYC = T_CD2UM_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned T_CCLK_MIN_PERIOD_NS = 8;
  localparam int unsigned T_CD2CU_NS = 4 * T_CCLK_MIN_PERIOD_NS;
  localparam int unsigned CD2CU_CYC = (T_CD2CU_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INIT_USR_EDGES = 8576;

  localparam int unsigned CNT_W = 16;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned WORD_W = 32;

  // Register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_LEN = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_DATA = 8'h0C;

  // Control fields
  localparam int unsigned CTRL_WIDTH_LSB = 0;
  localparam int unsigned CTRL_DECOMP_BIT = 2;
  localparam int unsigned CTRL_SEC_BIT = 3;
  localparam int unsigned CTRL_USRCLK_BIT = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0002;
  localparam logic [15:0] LEN_RST = 16'h0100;

  // Status fields
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_HEAD_BIT = 3;
  localparam int unsigned ST_OVF_BIT = 4;
  localparam int unsigned ST_USER_BIT = 5;
  localparam int unsigned ST_WCNT_LSB = 16;

  // Clock-to-data ratios
  localparam logic [3:0] RATIO_PLAIN = 4'h1;
  localparam logic [3:0] RATIO_SEC = 4'h4;
  localparam logic [3:0] RATIO_DEC = 4'h8;

  // Positions in the synchronised pin vector
  localparam int unsigned PIN_CCLK = 32;
  localparam int unsigned PIN_REQ = 33;
  localparam int unsigned PIN_STAT = 34;
  localparam int unsigned PIN_UCLK = 35;
  localparam int unsigned PIN_W = 36;

  typedef enum logic [1:0] {
    PCP_W_X8 = 2'h0,
    PCP_W_X16 = 2'h1,
    PCP_W_X32 = 2'h2,
    PCP_W_SERIAL = 2'h3
  } pcp_width_t;

  typedef enum logic [2:0] {
    PCP_ST_RESET = 3'h0,
    PCP_ST_LOAD = 3'h1,
    PCP_ST_TAIL = 3'h3,
    PCP_ST_INIT = 3'h2,
    PCP_ST_USER = 3'h6,
    PCP_ST_ERROR = 3'h7
  } pcp_state_t;

endpackage

// >>> rtl/pcp_stream_if.sv
`timescale 1ns/1ps
interface pcp_stream_if #(
  parameter int unsigned W = 32
);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;
  modport client(output wr_valid, output wr_data, output rd_ready, input wr_ready, input rd_valid, input rd_data);
  modport store(input wr_valid, input wr_data, input rd_ready, output wr_ready, output rd_valid, output rd_data);
endinterface

// >>> test/pcp_host_model.sv
`timescale 1ns/1ps
module pcp_host_model (
  // Link toward device
  output logic o_config_clock,
  output logic o_config_request_n,
  output logic [31:0] o_config_data_bus,
  output logic o_user_init_clock,
  // Sensed open-drain line
  input wire logic i_config_complete
);
  logic run_usr;
  initial begin
    o_config_clock = 1'b0;
    o_config_request_n = 1'b1;
    o_config_data_bus = 32'h0000_0000;
    o_user_init_clock = 1'b0;
    run_usr = 1'b0;
  end
  // Request level, launched after a reference edge
  task automatic req(input logic l);
    o_config_request_n <= l;
  endtask
  // One link cycle: data moves while the clock is low
  task automatic cyc(input logic [31:0] d);
    o_config_data_bus = d;
    #160 o_config_clock = 1'b1;
    #160 o_config_clock = 1'b0;
  endtask
  // Released bus must not keep the last word
  task automatic idle();
    o_config_data_bus = ~o_config_data_bus;
  endtask
  // Init clock starts as complete rises
  always @(posedge i_config_complete) run_usr = 1'b1;
  always @(negedge i_config_complete) run_usr = 1'b0;
  always #40 if (run_usr) o_user_init_clock = ~o_user_init_clock;
endmodule

// >>> test/test_passive_config_port_timing.sv
`timescale 1ns/1ps
module test_passive_config_port_timing;
  import pcp_pkg::*;
  localparam int ST_LOW = 80;
  localparam int OSC = 30;
  localparam int OSC_MAX = 60;
  localparam int USR = 5;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, cdata, rd;
  logic cclk, req_n, uclk, st_o, st_oe, cd_o, cd_oe, umode, err, ce;
  logic [31:0] wds[10];
  logic [4:0] mode[5] = '{5'h02, 5'h08, 5'h05, 5'h0F, 5'h12};
  int rat[5] = '{1, 4, 8, 8, 1};
  int miscompares, tests_run, n;
  wire st_w = ~st_oe;
  wire cd_w = ~cd_oe;

  pcp_loader #(.STATUS_LOW_CYC(ST_LOW), .INIT_OSC_CYC(OSC), .INIT_OSC_MAX_CYC(OSC_MAX),
    .INIT_USR_EDGES(USR), .FIFO_DEPTH(8)) dut_u (
    .i_ref_clk(clk), .i_nrst(nrst), .i_ce(ce),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_config_clock(cclk), .i_config_request_n(req_n), .i_config_data_bus(cdata),
    .i_user_init_clock(uclk), .i_config_status_n(st_w),
    .o_config_status_n_o(st_o), .o_config_status_n_oe(st_oe),
    .o_config_complete_o(cd_o), .o_config_complete_oe(cd_oe), .o_user_mode(umode));
  pcp_host_model host_u (.o_config_clock(cclk), .o_config_request_n(req_n), .o_config_data_bus(cdata),
    .o_user_init_clock(uclk), .i_config_complete(cd_w));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #2000000;
    miscompares++;
    summarize();
  end

  task automatic summarize();
    $display("Counts: %0d compares, %0d mismatches", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bound(input int k, input int lim);
    if (k >= lim) begin
      miscompares++;
      summarize();
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    bound(k, 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask
  task automatic reconfig();
    int k;
    @(posedge clk);
    host_u.req(1'b0);
    for (k = 0; k < 15 && (st_oe !== 1'b1 || cd_oe !== 1'b1); k++) @(posedge clk);
    check(k < 15, 1'b1);
    bound(k, 15);
    repeat (50 - k) @(posedge clk);
    host_u.req(1'b1);
    for (k = 0; k < ST_LOW + 10 && st_w !== 1'b1; k++) @(posedge clk);
    check(k >= ST_LOW - 54 && k < ST_LOW, 1'b1);
    bound(k, ST_LOW + 10);
    repeat (50) @(posedge clk);
  endtask
  task automatic load(input logic [1:0] wd, input int r, input int nw);
    int ub;
    logic [31:0] m, d;
    ub = (wd == 2'h0) ? 8 : (wd == 2'h1) ? 16 : (wd == 2'h2) ? 32 : 1;
    m = (ub == 32) ? 32'hFFFF_FFFF : (32'h1 << ub) - 32'h1;
    #7;
    for (int i = 0; i < nw; i++) begin
      for (int u = 0; u < 32 / ub; u++) begin
        d = ((wds[i] >> (u * ub)) & m) | (~m & {32{u[0]}});
        for (int k = 0; k < r; k++) begin
          host_u.cyc(k == 0 ? d : ~d);
          if (k == 1 && i == nw - 1 && u == 32 / ub - 1) check(cd_w, 1'b0);
        end
      end
    end
    host_u.idle();
  endtask

  initial begin
    nrst = 1'b0;
    ce = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    miscompares = 0;
    tests_run = 0;
    for (int i = 0; i < 10; i++) wds[i] = 32'h1E0F_C3A5 ^ (32'h0102_4081 * (i + 1));
    repeat (5) @(posedge clk);
    check({st_oe, cd_oe, umode, st_o, cd_o}, 5'b11000);
    nrst <= 1'b1;
    // Enable held low: the power-up pulse must not advance
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    for (n = 0; n < ST_LOW + 10 && st_w !== 1'b1; n++) @(posedge clk);
    check(n >= ST_LOW && n < ST_LOW + 10, 1'b1);
    bound(n, ST_LOW + 10);
    rdchk(OFF_CTRL, CTRL_RST);
    check(err, 1'b0);
    rdchk(OFF_LEN, {16'h0000, LEN_RST});
    rdchk(8'h10, 32'h0000_0000);
    check(err, 1'b1);
    apb(1'b1, 8'h14, 32'hFFFF_FFFF);
    check(err, 1'b1);
    rdchk(OFF_CTRL, CTRL_RST);
    $display("Test reset and map done");
    for (int t = 0; t < 5; t++) begin
      apb(1'b1, OFF_CTRL, {27'h0, mode[t]});
      apb(1'b1, OFF_LEN, 32'h0000_0002);
      reconfig();
      load(mode[t][1:0], rat[t], 2);
      for (n = 0; n < 400 && cd_w !== 1'b1; n++) @(posedge clk);
      bound(n, 400);
      for (n = 0; n < OSC_MAX + 10 && umode !== 1'b1; n++) @(posedge clk);
      if (mode[t][4]) check(n >= 2 * USR - 2 && n < 25, 1'b1);
      else check(n >= OSC - 2 && n <= OSC_MAX, 1'b1);
      bound(n, OSC_MAX + 10);
      rdchk(OFF_STATUS, 32'h0002_002E);
      rdchk(OFF_DATA, wds[0]);
      rdchk(OFF_DATA, wds[1]);
      rdchk(OFF_DATA, 32'h0000_0000);
      $display("Test mode %0d done", t);
    end
    apb(1'b1, OFF_CTRL, 32'h0000_0002);
    apb(1'b1, OFF_LEN, 32'h0000_0010);
    reconfig();
    load(2'h2, 1, 10);
    repeat (10) @(posedge clk);
    check(st_oe, 1'b1);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    check(rd[4:0], 5'h1F);
    apb(1'b1, OFF_STATUS, 32'h0000_0010);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    check(rd[4], 1'b0);
    for (int i = 0; i < 9; i++) rdchk(OFF_DATA, wds[i]);
    rdchk(OFF_DATA, 32'h0000_0000);
    reconfig();
    $display("Test overflow done");
    summarize();
  end
endmodule
